//--- rtl/tpts_cfg.svh
`ifndef TPTS_CFG_SVH
`define TPTS_CFG_SVH
// ---------------------------------------------
// Power table constants
// ---------------------------------------------
`define TPTS_LEVEL_W 8
`define TPTS_DEFAULT_LEVEL 8'hC6
`define TPTS_ENTRY0 1'b0
`define TPTS_ENTRY1 1'b1
`define TPTS_BAN_LO 8'h61
`define TPTS_BAN_HI 8'h6F
`define TPTS_PA_OFF 8'h00
// ---------------------------------------------
// Wake timing
// ---------------------------------------------
`define TPTS_WAKE_NS 150
`define TPTS_CLK_NS 25
`define TPTS_WAKE_CYC ((`TPTS_WAKE_NS + `TPTS_CLK_NS - 1) / `TPTS_CLK_NS)
`define TPTS_CNT_W 4
`endif

//--- rtl/tpts_pkg.sv
package tpts_pkg;
	typedef logic [7:0] tpts_level_t;
	typedef enum logic [1:0] {
		TPTS_ACTIVE = 2'b00,
		TPTS_ARMED = 2'b01,
		TPTS_DOWN = 2'b11,
		TPTS_WAKING = 2'b10
	} tpts_pwr_e;
endpackage

//--- rtl/tpts_power_ctrl.sv
`timescale 1ns/1ps
`include "tpts_cfg.svh"
module tpts_power_ctrl
	import tpts_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_ce,
	// Control
	input wire logic i_power_down_strobe,
	input wire logic i_chip_select_n,
	// Status
	output logic o_powered,
	output logic o_sleep_enter,
	output logic o_ready
);
	tpts_pwr_e state;
	logic [`TPTS_CNT_W-1:0] wake_cnt;

	// ---------------------------------------------
	// Power state machine
	// ---------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state <= TPTS_ACTIVE;
			wake_cnt <= '0;
		end else if (i_ce) begin
			case (state)
				TPTS_ACTIVE: begin
					if (i_power_down_strobe && !i_chip_select_n)
						state <= TPTS_ARMED;
				end
				TPTS_ARMED: begin
					if (i_chip_select_n)
						state <= TPTS_DOWN;
				end
				TPTS_DOWN: begin
					if (!i_chip_select_n) begin
						state <= TPTS_WAKING;
						wake_cnt <= '0;
					end
				end
				TPTS_WAKING: begin
					if (wake_cnt == `TPTS_CNT_W'(`TPTS_WAKE_CYC - 1))
						state <= TPTS_ACTIVE;
					else
						wake_cnt <= wake_cnt + 1'b1;
				end
				default: state <= TPTS_ACTIVE;
			endcase
		end
	end

	assign o_powered = (state != TPTS_DOWN);
	assign o_sleep_enter = (state == TPTS_ARMED) && i_chip_select_n;
	assign o_ready = (state == TPTS_ACTIVE) || (state == TPTS_ARMED);
endmodule

//--- rtl/tpts_tx_power_table_select.sv
`timescale 1ns/1ps
`include "tpts_cfg.svh"
module tpts_tx_power_table_select
	import tpts_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_ce,
	// Host serial side
	input wire logic i_chip_select_n,
	input wire logic i_power_down_strobe,
	// Table write port
	input wire logic i_table_wr,
	input wire logic i_table_burst,
	input wire logic i_table_first,
	input wire logic [7:0] i_table_data,
	// Front-end config
	input wire logic i_power_index_select,
	input wire logic i_ook_mode,
	// Transmit
	input wire logic i_tx_active,
	input wire logic i_tx_bit,
	// Outputs
	output logic [7:0] o_pa_level,
	output logic o_so,
	output logic o_so_oe_n,
	output logic o_powered,
	output logic o_xosc_on
);
	tpts_level_t power_level_table [2];
	logic burst_ptr;
	logic powered;
	logic sleep_enter;
	logic ready;
	logic wr_idx;
	logic sel_idx;

	function automatic logic pick_entry(input logic ook, input logic idx,
		input logic tx_bit);
		pick_entry = (ook && idx) ? tx_bit : idx;
	endfunction

	tpts_power_ctrl u_pwr (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_power_down_strobe(i_power_down_strobe),
		.i_chip_select_n(i_chip_select_n),
		.o_powered(powered),
		.o_sleep_enter(sleep_enter),
		.o_ready(ready)
	);

	// ---------------------------------------------
	// Table writes and retention
	// ---------------------------------------------
	// Single access always hits entry 0; burst walks entries
	assign wr_idx = (i_table_burst && !i_table_first) ? burst_ptr
		: `TPTS_ENTRY0;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			burst_ptr <= `TPTS_ENTRY0;
		end else if (i_ce) begin
			if (i_table_wr)
				burst_ptr <= ~wr_idx;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			power_level_table[0] <= `TPTS_DEFAULT_LEVEL;
			power_level_table[1] <= `TPTS_DEFAULT_LEVEL;
		end else if (i_ce) begin
			if (sleep_enter)
				power_level_table[1] <= `TPTS_DEFAULT_LEVEL;
			else if (i_table_wr && powered)
				power_level_table[wr_idx] <= i_table_data;
		end
	end

	// ---------------------------------------------
	// Amplifier level selection
	// ---------------------------------------------
	// Index 1 with on-off keying follows the data bit
	assign sel_idx = pick_entry(i_ook_mode, i_power_index_select,
		i_tx_bit);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_pa_level <= `TPTS_PA_OFF;
		end else if (i_ce) begin
			if (i_tx_active && powered)
				o_pa_level <= power_level_table[sel_idx];
			else
				o_pa_level <= `TPTS_PA_OFF;
		end
	end

	// ---------------------------------------------
	// Power and ready outputs
	// ---------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_powered <= 1'b1;
			o_xosc_on <= 1'b1;
			o_so <= 1'b1;
			o_so_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_powered <= powered;
			o_xosc_on <= powered;
			o_so <= !ready;
			o_so_oe_n <= i_chip_select_n;
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	pa_idle_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && !i_tx_active |=> o_pa_level == `TPTS_PA_OFF)
		else $error("pa level set outside transmit");
	pa_select_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && i_tx_active && powered && !i_table_wr && !sleep_enter
		|=> o_pa_level == $past(power_level_table[sel_idx]))
		else $error("pa level not selected entry");
	ook_follow_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && i_tx_active && powered && i_ook_mode && i_power_index_select
		|=> o_pa_level == $past(power_level_table[i_tx_bit]))
		else $error("ook level not following bit");
	sleep_retain_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && sleep_enter |=>
		power_level_table[1] == `TPTS_DEFAULT_LEVEL &&
		power_level_table[0] == $past(power_level_table[0]))
		else $error("sleep retention wrong");
	single_wr_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && i_table_wr && powered && !sleep_enter && !i_table_burst
		|=> power_level_table[0] == $past(i_table_data))
		else $error("single write missed entry 0");
	pd_wait_cs_a: assert property (@(posedge i_clock) disable iff (i_srst)
		!i_chip_select_n && powered |=> powered)
		else $error("power lost with select low");
	wake_cs_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && !powered && !i_chip_select_n |=> ##1 o_xosc_on)
		else $error("no wake on select low");
	ready_low_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && $fell(powered) ##1 i_ce && !i_chip_select_n
		##1 i_ce [*8] |-> !o_so)
		else $error("ready not shown after wake");
	reset_default_a: assert property (@(posedge i_clock)
		$past(i_srst) |-> power_level_table[0] == `TPTS_DEFAULT_LEVEL)
		else $error("default level missing");

	// ---------------------------------------------
	// Further checks
	// ---------------------------------------------
	burst_first_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && i_table_wr && powered && i_table_burst && i_table_first
		|=> power_level_table[0] == $past(i_table_data))
		else $error("burst first byte missed entry 0");

	burst_next_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && i_table_wr && powered && !sleep_enter && i_table_burst &&
		!i_table_first && $past(i_ce && i_table_wr && i_table_burst &&
		i_table_first && powered)
		|=> power_level_table[1] == $past(i_table_data))
		else $error("burst second byte missed entry 1");

	down_hold0_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && !powered
		|=> power_level_table[0] == $past(power_level_table[0]))
		else $error("entry 0 changed while down");

	down_hold1_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && !powered
		|=> power_level_table[1] == $past(power_level_table[1]))
		else $error("entry 1 changed while down");

	down_pa_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && !powered |=> o_pa_level == `TPTS_PA_OFF)
		else $error("pa level set while down");

	plain_sel_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && i_tx_active && powered && !i_ook_mode
		|=> o_pa_level == $past(power_level_table[i_power_index_select]))
		else $error("index did not pick entry");

	powered_reg_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce |=> o_powered == $past(powered))
		else $error("powered output lags state");

	xosc_reg_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce |=> o_xosc_on == $past(powered))
		else $error("oscillator output lags state");

	sleep_cs_high_a: assert property (@(posedge i_clock)
		disable iff (i_srst)
		i_ce && sleep_enter |-> i_chip_select_n)
		else $error("sleep entered with select low");

	sleep_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && sleep_enter |=> !powered)
		else $error("power stayed on after select high");

	cs_wake_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && !i_chip_select_n && !powered |=> powered)
		else $error("select low did not restore power");

	so_busy_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && !ready |=> o_so)
		else $error("data out low before ready");

	so_ready_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce && ready |=> !o_so)
		else $error("data out high while ready");

	oe_follow_a: assert property (@(posedge i_clock) disable iff (i_srst)
		i_ce |=> o_so_oe_n == $past(i_chip_select_n))
		else $error("output enable not following select");

	wake_busy_a: assert property (@(posedge i_clock) disable iff (i_srst)
		$rose(powered) |-> !ready)
		else $error("ready shown at power return");
endmodule

//--- testbench/tpts_host_model.sv
`timescale 1ns/1ps
module tpts_host_model (
	// Device side
	input wire logic i_clock,
	input wire logic i_so,
	// Host drive
	output logic o_chip_select_n,
	output logic o_power_down_strobe,
	output logic o_table_wr,
	output logic o_table_burst,
	output logic o_table_first,
	output logic [7:0] o_table_data
);
	initial begin
		o_chip_select_n = 1'b1;
		o_power_down_strobe = 1'b0;
		o_table_wr = 1'b0;
		o_table_burst = 1'b0;
		o_table_first = 1'b0;
		o_table_data = 8'hFF;
	end
	// Held over back-to-back calls for bursts
	task automatic put(input logic [7:0] d, input logic b, input logic f);
		if (d >= 8'h61 && d <= 8'h6F) return;
		@(posedge i_clock) #2;
		o_chip_select_n = 1'b0;
		o_table_wr = 1'b1;
		o_table_burst = b;
		o_table_first = f;
		o_table_data = d;
	endtask
	task automatic rel();
		@(posedge i_clock) #2;
		o_table_wr = 1'b0;
		o_table_data = ~o_table_data;
		o_chip_select_n = 1'b1;
	endtask
	task automatic power_down();
		@(posedge i_clock) #2;
		o_chip_select_n = 1'b0;
		o_power_down_strobe = 1'b1;
		@(posedge i_clock) #2;
		o_power_down_strobe = 1'b0;
		o_chip_select_n = 1'b1;
	endtask
	// Waits for ready before any clocking
	task automatic wake(output bit ok);
		ok = 1'b0;
		@(posedge i_clock) #2;
		o_chip_select_n = 1'b0;
		repeat (40) begin
			@(posedge i_clock) #1;
			if (i_so === 1'b0) begin
				ok = 1'b1;
				break;
			end
		end
	endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0, srst = 1'b1, tx = 1'b0, bitv = 1'b0;
	logic sel = 1'b0, ook = 1'b0, ce = 1'b1;
	logic cs_n, pds, wr, bur, fst, so, oe_n, pwr, xo;
	logic [7:0] dat, lvl;
	int fail_count = 0, comparisons = 0;
	bit ok;
	always #12.5 clk = ~clk;
	tpts_tx_power_table_select dut_u (.i_clock(clk), .i_srst(srst),
		.i_ce(ce), .i_chip_select_n(cs_n), .i_power_down_strobe(pds),
		.i_table_wr(wr), .i_table_burst(bur), .i_table_first(fst),
		.i_table_data(dat), .i_power_index_select(sel), .i_ook_mode(ook),
		.i_tx_active(tx), .i_tx_bit(bitv), .o_pa_level(lvl), .o_so(so),
		.o_so_oe_n(oe_n), .o_powered(pwr), .o_xosc_on(xo));
	tpts_host_model host_u (.i_clock(clk), .i_so(so), .o_chip_select_n(cs_n),
		.o_power_down_strobe(pds), .o_table_wr(wr), .o_table_burst(bur),
		.o_table_first(fst), .o_table_data(dat));
	task automatic cmp(input string n, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic lv(input logic s, b, o, input logic [7:0] e);
		@(posedge clk) #2;
		sel = s;
		bitv = b;
		ook = o;
		repeat (2) @(posedge clk);
		#1;
		cmp("pa_level", e, lvl);
	endtask
	task automatic freeze();
		@(posedge clk) #2;
		ce = 1'b0;
		sel = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		cmp("pa_level", 8'h12, lvl);
		#1;
		ce = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		cmp("pa_level", 8'hC6, lvl);
	endtask
	task automatic stop_test();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#50000;
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		#2;
		srst = 1'b0;
		tx = 1'b1;
		lv(0, 0, 0, 8'hC6);
		lv(1, 0, 0, 8'hC6);
		host_u.put(8'hA5, 0, 0);
		host_u.rel();
		lv(0, 0, 0, 8'hA5);
		host_u.put(8'h12, 1, 1);
		host_u.put(8'h34, 1, 0);
		host_u.rel();
		lv(0, 0, 0, 8'h12);
		lv(1, 0, 0, 8'h34);
		lv(1, 0, 1, 8'h12);
		lv(1, 1, 1, 8'h34);
		lv(0, 1, 1, 8'h12);
		@(posedge clk) #2;
		tx = 1'b0;
		lv(1, 1, 0, 8'h00);
		host_u.power_down();
		cmp("powered", 8'h01, {7'h00, pwr});
		repeat (6) @(posedge clk);
		#1;
		cmp("powered", 8'h00, {7'h00, pwr});
		cmp("xosc_on", 8'h00, {7'h00, xo});
		host_u.wake(ok);
		cmp("ready", 8'h01, {7'h00, ok});
		cmp("powered", 8'h01, {7'h00, pwr});
		cmp("xosc_on", 8'h01, {7'h00, xo});
		host_u.rel();
		@(posedge clk) #2;
		tx = 1'b1;
		lv(1, 0, 0, 8'hC6);
		lv(0, 0, 0, 8'h12);
		host_u.put(8'h65, 0, 0);
		host_u.rel();
		lv(0, 0, 0, 8'h12);
		freeze();
		host_u.power_down();
		@(posedge clk);
		host_u.wake(ok);
		cmp("ready", 8'h01, {7'h00, ok});
		cmp("so_oe_n", 8'h00, {7'h00, oe_n});
		host_u.rel();
		stop_test();
	end
endmodule
